// ---- slew_ntc_pkg.sv ----
// Constants shared by the reference-slew and thermistor-fault register bank.
// Assumes one 200 MHz system clock; the command port carries decoded
// PMBus command transactions from a front end that owns the bus pins.
// Notes on behaviour
// - New setpoint reached gradually at programmed rate
// - On/off reference moves ignore the programmed rate
// - Rate bits 2:0 pick 12.5 to 1600 mV/ms
// - Rate word is two bytes; bits 15:3 unused
// - Rate resets to 0004h, 200 mV/ms
// - Threshold bits 9:0, 2 mV/count, versus thermistor reading
// - Threshold word two bytes; bits 15:10 ignored
// - Threshold resets to 0096h, 300 mV
// - Fault raised when thermistor reading below threshold
// - Threshold writable and reads back stored value
// - Setpoint is 8-bit unsigned, 8 mV/count
// - Reads always work; writes blocked by lock code
package slew_ntc_pkg;

  localparam int unsigned WORD_W   = 16;
  localparam int unsigned CODE_W   = 8;
  localparam int unsigned RATE_W   = 3;
  localparam int unsigned THR_W    = 10;
  localparam int unsigned DAC_W    = 8;
  localparam int unsigned LOCK_W   = 8;

  // Command codes of the two registers
  localparam logic [CODE_W-1:0] CMD_SLEW_RATE = 8'h27;
  localparam logic [CODE_W-1:0] CMD_TEMP_THR  = 8'h4f;

  // Reset values
  localparam logic [RATE_W-1:0] SLEW_RATE_RESET = 3'h4;
  localparam logic [THR_W-1:0]  TEMP_THR_RESET  = 10'h096;

  // Write lock: only zero leaves writes open
  localparam logic [LOCK_W-1:0] LOCK_OPEN = 8'h00;

  // Fastest rate code; each lower code doubles the step interval
  localparam logic [RATE_W-1:0] RATE_CODE_MAX = 3'h7;

  // One DAC count is 8 mV; at 1600 mV/ms a count takes 5000 ns
  localparam int unsigned DAC_STEP_MV       = 8;
  localparam int unsigned FASTEST_RATE_MVMS = 1600;
  localparam int unsigned STEP_NS_FASTEST   = 5000;
  localparam int unsigned CLK_MHZ           = 200;
  localparam int unsigned STEP_CYC_FASTEST  =
    (STEP_NS_FASTEST * CLK_MHZ) / 1000;

  // Slowest interval is 128 times the fastest
  localparam int unsigned STEP_CNT_W = 17;

endpackage

// ---- thermistor_compare.sv ----
// Board over-temperature comparator on thermistor readings.
// Assumes readings arrive on clk_in as 2 mV/count codes with a valid strobe.
`timescale 1ns/1ps
module thermistor_compare (
  input  wire logic                           clk_in,
  input  wire logic                           rst_in,
  input  wire logic [slew_ntc_pkg::THR_W-1:0] reading_in,
  input  wire logic                           reading_valid_in,
  input  wire logic [slew_ntc_pkg::THR_W-1:0] threshold_in,
  output logic                                fault_out,
  output logic                                fault_event_out
);
  import slew_ntc_pkg::*;

  logic fault_r;
  logic fault_nxt;
  logic event_r;
  logic event_nxt;

  // Lower voltage means hotter board; held until the next sample
  always_comb begin
    fault_nxt = fault_r;
    event_nxt = 1'b0;
    if (reading_valid_in) begin
      fault_nxt = (reading_in < threshold_in);
      event_nxt = (reading_in < threshold_in) && !fault_r;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fault_r <= 1'b0;
      event_r <= 1'b0;
    end else begin
      fault_r <= fault_nxt;
      event_r <= event_nxt;
    end
  end

  assign fault_out       = fault_r;
  assign fault_event_out = event_r;

endmodule // thermistor_compare

// ---- ref_slew_ntc_regs.sv ----
// Reference slew-rate and thermistor fault-threshold registers with the
// reference DAC slew engine and the board over-temperature comparator.
// Assumes a PMBus front end delivers one decoded command per request
// pulse, and that setpoint, unit-on and lock code come from logic on clk_in.
`timescale 1ns/1ps
module ref_slew_ntc_regs #(
  parameter int unsigned STEP_CYC = slew_ntc_pkg::STEP_CYC_FASTEST
) (
  input  wire logic                            clk_in,
  input  wire logic                            rst_in,
  // Decoded command port
  input  wire logic                            cmd_req_in,
  input  wire logic                            cmd_write_in,
  input  wire logic [slew_ntc_pkg::CODE_W-1:0] cmd_code_in,
  input  wire logic [slew_ntc_pkg::WORD_W-1:0] cmd_wdata_in,
  input  wire logic [slew_ntc_pkg::LOCK_W-1:0] write_lock_in,
  output logic                                 cmd_ack_out,
  output logic                                 cmd_nak_out,
  output logic      [slew_ntc_pkg::WORD_W-1:0] cmd_rdata_out,
  // Converter side
  input  wire logic [slew_ntc_pkg::DAC_W-1:0]  output_setpoint_in,
  input  wire logic                            unit_on_in,
  output logic      [slew_ntc_pkg::DAC_W-1:0]  ref_dac_out,
  output logic                                 slew_busy_out,
  // Thermistor side
  input  wire logic [slew_ntc_pkg::THR_W-1:0]  thermistor_input_in,
  input  wire logic                            thermistor_valid_in,
  output logic                                 board_overtemp_fault_out,
  output logic                                 board_overtemp_event_out
);
  import slew_ntc_pkg::*;

  // Register bank state
  logic [RATE_W-1:0] reference_slew_rate_r;
  logic [RATE_W-1:0] reference_slew_rate_nxt;
  logic [THR_W-1:0]  board_temp_fault_threshold_r;
  logic [THR_W-1:0]  board_temp_fault_threshold_nxt;

  // Command answer state
  logic              ack_r;
  logic              ack_nxt;
  logic              nak_r;
  logic              nak_nxt;
  logic [WORD_W-1:0] rdata_r;
  logic [WORD_W-1:0] rdata_nxt;

  // Slew engine state
  logic [DAC_W-1:0]      ref_r;
  logic [DAC_W-1:0]      ref_nxt;
  logic                  on_r;
  logic                  on_nxt;
  logic [STEP_CNT_W-1:0] tick_cnt_r;
  logic [STEP_CNT_W-1:0] tick_cnt_nxt;

  // Decode helpers
  logic              hit_rate;
  logic              hit_thr;
  logic              mapped;
  logic              locked;
  logic              wr_ok;
  logic [WORD_W-1:0] rate_word;
  logic [WORD_W-1:0] thr_word;

  // Slew helpers
  logic [RATE_W-1:0]     shift_amt;
  logic [STEP_CNT_W-1:0] interval;
  logic                  at_target;
  logic                  step_due;

  // Command decode
  assign hit_rate = (cmd_code_in == CMD_SLEW_RATE);
  assign hit_thr  = (cmd_code_in == CMD_TEMP_THR);
  assign mapped   = hit_rate || hit_thr;
  assign locked   = (write_lock_in != LOCK_OPEN);
  assign wr_ok    = cmd_req_in && cmd_write_in && mapped && !locked;

  // Unused upper bits read back as zero
  assign rate_word = {{(WORD_W-RATE_W){1'b0}},
                      reference_slew_rate_r};
  assign thr_word  = {{(WORD_W-THR_W){1'b0}},
                      board_temp_fault_threshold_r};

  // Register writes
  always_comb begin
    reference_slew_rate_nxt        = reference_slew_rate_r;
    board_temp_fault_threshold_nxt = board_temp_fault_threshold_r;
    if (wr_ok && hit_rate) begin
      // Only the rate field is kept; bits 15:3 are dropped
      reference_slew_rate_nxt = cmd_wdata_in[RATE_W-1:0];
    end
    if (wr_ok && hit_thr) begin
      // Bits 15:10 are ignored on write
      board_temp_fault_threshold_nxt =
        cmd_wdata_in[THR_W-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reference_slew_rate_r        <= SLEW_RATE_RESET;
      board_temp_fault_threshold_r <= TEMP_THR_RESET;
    end else begin
      reference_slew_rate_r        <= reference_slew_rate_nxt;
      board_temp_fault_threshold_r <= board_temp_fault_threshold_nxt;
    end
  end

  // Command answers: one cycle after the request
  always_comb begin
    ack_nxt   = 1'b0;
    nak_nxt   = 1'b0;
    rdata_nxt = rdata_r;
    if (cmd_req_in) begin
      if (!mapped) begin
        nak_nxt = 1'b1;
      end else if (cmd_write_in) begin
        // A locked write is refused, stored values untouched
        ack_nxt = !locked;
        nak_nxt = locked;
      end else begin
        // Reads never consult the lock
        ack_nxt   = 1'b1;
        rdata_nxt = hit_rate ? rate_word : thr_word;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ack_r   <= 1'b0;
      nak_r   <= 1'b0;
      rdata_r <= '0;
    end else begin
      ack_r   <= ack_nxt;
      nak_r   <= nak_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign cmd_ack_out   = ack_r;
  assign cmd_nak_out   = nak_r;
  assign cmd_rdata_out = rdata_r;

  // Step interval from the rate code
  // Each code below the fastest halves the rate, so the interval
  // between 8 mV steps doubles: 1600 mV/ms gives STEP_CYC cycles.
  assign shift_amt = RATE_CODE_MAX - reference_slew_rate_r;
  assign interval  = STEP_CNT_W'(STEP_CYC) << shift_amt;

  assign at_target = (ref_r == output_setpoint_in);
  assign step_due  = (tick_cnt_r >= interval - STEP_CNT_W'(1));

  // Reference DAC slew engine
  // Setpoint is an 8 mV/count code, so one DAC count is one step
  always_comb begin
    ref_nxt      = ref_r;
    tick_cnt_nxt = tick_cnt_r;
    on_nxt       = unit_on_in;
    if (!unit_on_in) begin
      // Turn-off drops the reference at once, outside the slew
      ref_nxt      = '0;
      tick_cnt_nxt = '0;
    end else if (!on_r) begin
      // Turn-on loads the setpoint directly; soft-start is elsewhere
      ref_nxt      = output_setpoint_in;
      tick_cnt_nxt = '0;
    end else if (at_target) begin
      // Idle: restart timing so the first step takes a full interval
      tick_cnt_nxt = '0;
    end else if (step_due) begin
      tick_cnt_nxt = '0;
      if (output_setpoint_in > ref_r) begin
        ref_nxt = ref_r + DAC_W'(1);
      end else begin
        ref_nxt = ref_r - DAC_W'(1);
      end
    end else begin
      tick_cnt_nxt = tick_cnt_r + STEP_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ref_r      <= '0;
      on_r       <= 1'b0;
      tick_cnt_r <= '0;
    end else begin
      ref_r      <= ref_nxt;
      on_r       <= on_nxt;
      tick_cnt_r <= tick_cnt_nxt;
    end
  end

  assign ref_dac_out   = ref_r;
  assign slew_busy_out = on_r && !at_target;

  // Board over-temperature comparison
  thermistor_compare u_thermistor_compare (
    .clk_in           (clk_in),
    .rst_in           (rst_in),
    .reading_in       (thermistor_input_in),
    .reading_valid_in (thermistor_valid_in),
    .threshold_in     (board_temp_fault_threshold_r),
    .fault_out        (board_overtemp_fault_out),
    .fault_event_out  (board_overtemp_event_out)
  );

endmodule // ref_slew_ntc_regs

// ---- ref_slew_ntc_regs_asserts.sv ----
// Port-level checker for the slew and thermistor register bank.
// Sees only the top module's ports; bound to every instance below.
`timescale 1ns/1ps
module ref_slew_ntc_regs_asserts (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        cmd_req_in,
  input wire logic        cmd_write_in,
  input wire logic [7:0]  cmd_code_in,
  input wire logic [15:0] cmd_wdata_in,
  input wire logic [7:0]  write_lock_in,
  input wire logic        cmd_ack_out,
  input wire logic        cmd_nak_out,
  input wire logic [15:0] cmd_rdata_out,
  input wire logic [7:0]  output_setpoint_in,
  input wire logic        unit_on_in,
  input wire logic [7:0]  ref_dac_out,
  input wire logic [9:0]  thermistor_input_in,
  input wire logic        thermistor_valid_in,
  input wire logic        board_overtemp_fault_out,
  input wire logic        board_overtemp_event_out
);
  logic [9:0] thr_r;
  logic [9:0] thr_nxt;
  wire rd_go = cmd_req_in && !cmd_write_in;
  // Shadow of the stored threshold, so compares need no hierarchy
  always_comb begin
    thr_nxt = thr_r;
    if (cmd_req_in && cmd_write_in && cmd_code_in == 8'h4f &&
        write_lock_in == 8'h00) thr_nxt = cmd_wdata_in[9:0];
  end
  always_ff @(posedge clk_in) thr_r <= rst_in ? 10'h096 : thr_nxt;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  answer_once_a: assert property (cmd_req_in |=> cmd_ack_out ^ cmd_nak_out)
    else $error("command not answered once");
  no_request_a: assert property (!cmd_req_in |=> !cmd_ack_out && !cmd_nak_out)
    else $error("answer without request");
  locked_nak_a: assert property (cmd_req_in && cmd_write_in &&
    write_lock_in != 8'h00 |=> cmd_nak_out) else $error("locked write taken");
  rate_read_a: assert property (rd_go && cmd_code_in == 8'h27 |=>
    cmd_ack_out && cmd_rdata_out[15:3] == 13'h0) else $error("rate read");
  thr_read_a: assert property (rd_go && cmd_code_in == 8'h4f |=>
    cmd_ack_out && cmd_rdata_out == {6'h0, $past(thr_r)})
    else $error("threshold read");
  off_zero_a: assert property (!unit_on_in |=> ref_dac_out == 8'h00)
    else $error("reference not zero when off");
  turn_on_a: assert property ($rose(unit_on_in) |=>
    ref_dac_out == $past(output_setpoint_in)) else $error("turn-on load");
  step_one_a: assert property (!$past(rst_in) && unit_on_in &&
    $past(unit_on_in) |=> ref_dac_out == $past(ref_dac_out) ||
    ref_dac_out == $past(ref_dac_out) + 8'h01 ||
    ref_dac_out == $past(ref_dac_out) - 8'h01) else $error("slew jump");
  fault_cmp_a: assert property (thermistor_valid_in |=>
    board_overtemp_fault_out == ($past(thermistor_input_in) < $past(thr_r)))
    else $error("fault compare");
  event_edge_a: assert property
    (board_overtemp_event_out == $rose(board_overtemp_fault_out))
    else $error("fault event");
  cover property (cmd_nak_out);
  cover property (board_overtemp_event_out);
  cover property (unit_on_in && ref_dac_out != output_setpoint_in);
endmodule // ref_slew_ntc_regs_asserts

bind ref_slew_ntc_regs ref_slew_ntc_regs_asserts u_ref_slew_ntc_regs_asserts (
  .clk_in, .rst_in, .cmd_req_in, .cmd_write_in, .cmd_code_in, .cmd_wdata_in,
  .write_lock_in, .cmd_ack_out, .cmd_nak_out, .cmd_rdata_out,
  .output_setpoint_in, .unit_on_in, .ref_dac_out, .thermistor_input_in,
  .thermistor_valid_in, .board_overtemp_fault_out, .board_overtemp_event_out);

// ---- pmbus_host_model.sv ----
// Host model issuing decoded register commands, one per call.
// Drives just after clk_in edges; released lines show inverted values.
`timescale 1ns/1ps
module pmbus_host_model (
  input  wire logic        clk_in,
  output logic             req_out,
  output logic             write_out,
  output logic [7:0]       code_out,
  output logic [15:0]      wdata_out,
  input  wire logic        ack_in,
  input  wire logic        nak_in,
  input  wire logic [15:0] rdata_in
);
  initial begin
    req_out = 1'b0;
    write_out = 1'b0;
    code_out = 8'h00;
    wdata_out = 16'h0000;
  end
  // Idle cycles model a slow host between commands
  task automatic xfer(input logic w, input logic [7:0] c,
                      input logic [15:0] d, input int idle,
                      output logic a, output logic n,
                      output logic [15:0] q);
    repeat (idle) @(posedge clk_in);
    @(posedge clk_in) begin
      req_out <= 1'b1;
      write_out <= w;
      code_out <= c;
      wdata_out <= d;
    end
    @(posedge clk_in) begin
      req_out <= 1'b0;
      write_out <= ~w;
      code_out <= ~c;
      wdata_out <= ~d;
    end
    #1;
    a = ack_in;
    n = nak_in;
    q = rdata_in;
  endtask
endmodule // pmbus_host_model

// ---- ref_slew_ntc_regs_bench.sv ----
// Bench for the slew and thermistor register bank.
// Host model issues commands; bench drives converter and thermistor.
`timescale 1ns/1ps
module ref_slew_ntc_regs_bench;
  localparam int STEP = 4;
  logic        clk_in = 1'b0;
  logic        rst = 1'b1, on = 1'b0, tv = 1'b0;
  logic [7:0]  lock = 8'h00, sp = 8'h00;
  logic [9:0]  rd = 10'h000;
  logic        req, wr, ack, nak, busy, flt, evt;
  logic [7:0]  code, dac;
  logic [15:0] wd, rdat;
  int          num_errors = 0, total_checks = 0;
  pmbus_host_model u_pmbus_host_model (.clk_in, .req_out(req),
    .write_out(wr), .code_out(code), .wdata_out(wd), .ack_in(ack),
    .nak_in(nak), .rdata_in(rdat));
  ref_slew_ntc_regs #(.STEP_CYC(STEP)) u_ref_slew_ntc_regs (.clk_in,
    .rst_in(rst), .cmd_req_in(req), .cmd_write_in(wr), .cmd_code_in(code),
    .cmd_wdata_in(wd), .write_lock_in(lock), .cmd_ack_out(ack),
    .cmd_nak_out(nak), .cmd_rdata_out(rdat), .output_setpoint_in(sp),
    .unit_on_in(on), .ref_dac_out(dac), .slew_busy_out(busy),
    .thermistor_input_in(rd), .thermistor_valid_in(tv),
    .board_overtemp_fault_out(flt), .board_overtemp_event_out(evt));
  initial forever #2.5 clk_in = ~clk_in;
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  // Reads compare against d; writes are slowed by two idle cycles
  task automatic cmd(input logic w, input logic [7:0] c,
                     input logic [15:0] d, input logic ok);
    logic a, n;
    logic [15:0] q;
    u_pmbus_host_model.xfer(w, c, d, w ? 2 : 0, a, n, q);
    chk(a === ok && n === !ok, "answer");
    if (!w && ok) chk(q === d, "read data");
  endtask
  task automatic t_fields;
    cmd(0, 8'h27, 16'h0004, 1);
    cmd(0, 8'h4f, 16'h0096, 1);
    cmd(1, 8'h27, 16'hfff9, 1);
    cmd(0, 8'h27, 16'h0001, 1);
    cmd(1, 8'h4f, 16'hfc35, 1);
    cmd(0, 8'h4f, 16'h0035, 1);
    cmd(0, 8'h28, 16'h0000, 0);
    cmd(1, 8'h00, 16'h0000, 0);
    @(posedge clk_in) lock <= 8'h80;
    cmd(1, 8'h4f, 16'h0123, 0);
    cmd(1, 8'h27, 16'h0002, 0);
    cmd(0, 8'h4f, 16'h0035, 1);
    cmd(0, 8'h27, 16'h0001, 1);
    @(posedge clk_in) lock <= 8'h00;
    cmd(1, 8'h4f, 16'h0096, 1);
    cmd(0, 8'h4f, 16'h0096, 1);
  endtask
  task automatic t_onoff;
    @(posedge clk_in) begin
      sp <= 8'h5a;
      on <= 1'b1;
    end
    @(posedge clk_in) #1 chk(dac === 8'h5a, "turn-on load");
    @(posedge clk_in) on <= 1'b0;
    @(posedge clk_in) #1 chk(dac === 8'h00, "turn-off");
    @(posedge clk_in) begin
      sp <= 8'hf6;
      on <= 1'b1;
    end
    @(posedge clk_in) #1 chk(dac === 8'hf6, "turn-on load");
  endtask
  task automatic t_slew;
    int n;
    logic [7:0] tgt;
    for (int r = 0; r < 8; r++) begin
      cmd(1, 8'h27, 16'(r), 1);
      // Odd codes slew downward so both step directions are seen
      tgt = r[0] ? dac - 8'h01 : dac + 8'h01;
      @(posedge clk_in) sp <= tgt;
      n = 0;
      #1;
      while (dac !== sp && n < 600) begin
        @(posedge clk_in) #1 n++;
        if (n == 2) chk(busy === 1'b1, "busy");
      end
      chk(n >= (STEP << (7 - r)) - 1 &&
          n <= (STEP << (7 - r)) + 1, "step interval");
      chk(busy === 1'b0, "settle");
    end
  endtask
  task automatic smp(input logic [9:0] v, input logic f, input logic e);
    @(posedge clk_in) begin
      rd <= v;
      tv <= 1'b1;
    end
    @(posedge clk_in) begin
      rd <= ~v;
      tv <= 1'b0;
    end
    #1 chk(flt === f && evt === e, "fault");
  endtask
  task automatic t_therm;
    smp(10'd150, 0, 0);
    smp(10'd149, 1, 1);
    smp(10'd148, 1, 0);
    smp(10'd300, 0, 0);
    cmd(1, 8'h4f, 16'h012c, 1);
    smp(10'd299, 1, 1);
  endtask
  task automatic final_report;
    if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    rst <= 1'b0;
    t_fields();
    t_onoff();
    t_slew();
    t_therm();
    final_report();
  end
  // Whole run needs about 1150 cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    final_report();
  end
endmodule // ref_slew_ntc_regs_bench
